// file: netport_pkg.sv
// Constants and carrier types for the network instruction port manager.
// Assumes a 250 MHz sys_clk and an AXI4-Lite master with 32-bit data.
package netport_pkg;
  localparam int NPORTS = 8;
  localparam logic [7:0] OFS_IDLE = 8'h00;
  localparam logic [7:0] OFS_FAULT = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_ISSUE = 8'h3C;
  localparam logic [7:0] OFS_RXLIM = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  localparam logic [7:0] IDLE_RST = 8'hFF;
  localparam logic [15:0] WORDS_MIN = 16'h0001;
  localparam logic [15:0] WORDS_MAX = 16'h0100;
  localparam logic [7:0] NET_MAX = 8'h7F;
  localparam logic [7:0] NODE_LOCAL = 8'h00;
  localparam logic [7:0] NODE_BCAST = 8'hFF;
  localparam logic [15:0] C3_MBZ = 16'h70F0;
  localparam int C3_PORT_LSB = 8;
  localparam int C3_PORT_HI = 11;
  localparam int C3_NORSP = 15;
  localparam logic [15:0] CMD_TX_MAX = 16'h021E;
  localparam logic [15:0] CODE_TMO = 16'h0205;
  localparam logic [15:0] CODE_TXLONG = 16'h1103;
  localparam logic [15:0] CODE_RXLONG = 16'h1104;
  localparam logic [15:0] TMO_DEFAULT = 16'h0014;
  localparam int CLK_NS = 4;
  localparam int TENTH_NS = 100000000;
  localparam int TICK_CYCLES = (TENTH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KIND_SEND = 2'b00, KIND_RECV = 2'b01, KIND_CMD = 2'b10, KIND_BAD = 2'b11
  } kind_type;
  typedef enum logic [2:0] {
    UC_CPU = 3'b000, UC_APP = 3'b001, UC_BUS = 3'b010, UC_INNER = 3'b011,
    UC_NET = 3'b100, UC_BAD = 3'b111
  } unitcls_type;
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00, PS_QUEUED = 2'b01, PS_SEND = 2'b11, PS_WAIT = 2'b10
  } portst_type;
  typedef enum logic [2:0] {
    RK_IDLE = 3'b000, RK_FAULT = 3'b001, RK_RESULT = 3'b010, RK_CTRL = 3'b011,
    RK_ISSUE = 3'b100, RK_RXLIM = 3'b101, RK_STATUS = 3'b110, RK_NONE = 3'b111
  } regk_type;
  typedef struct packed {
    logic [2:0] port;
    kind_type kind;
    logic [6:0] net;
    logic [7:0] node;
    logic [7:0] unit;
    unitcls_type cls;
    logic [8:0] words;
    logic [15:0] txBytes;
  } netReq_type;
  typedef struct packed {
    logic [2:0] port;
    logic [15:0] bytes;
    logic [15:0] code;
  } netRsp_type;
endpackage

// file: netport_mgr.sv
// Port manager and control word checker for network instructions.
// Assumes a network unit on sys_clk that takes one request per handshake
// and returns responses tagged with the port number.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: Eight ports, one instruction each at once
// RULE_02: Idle flag bit per port, 1 when idle
// RULE_03: Fault flag bit per port, bit equals port
// RULE_04: Result word cleared at start, set at end
// RULE_05: Port held by protocol macro refuses instructions
// RULE_06: No response in time sets fault and code
// RULE_07: Command over 542 bytes aborts with fault
// RULE_08: Oversized response faults, nothing stored
// RULE_09: Other errors only in remote code
// RULE_10: Word count must be 1 to 256
// RULE_11: Network 0 to 127, high byte zero
// RULE_12: Unit low byte, node high, FF broadcast
// RULE_13: Decode unit address into destination class
// RULE_14: Retries, port, zero bits, no-response bit
// RULE_15: Monitor time in tenths of a second
// RULE_16: Zero monitor time means two seconds
// RULE_17: Send to own CPU is refused
// RULE_18: Network 0 resolves to lowest unit's network
// RULE_19: Software checks idle bit before issuing
// RULE_20: Source data kept stable while busy
// RULE_21: Broadcast expects no response, no retries
// RULE_22: Retransmit up to retry count on silence
// RULE_23: Flags and result update with idle bit
module netport_mgr #(
  parameter int unsigned TICK = netport_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] protoBusy,
  input wire logic [6:0] lowestNet,
  input wire logic [7:0] ownNode,
  output logic reqValid,
  input wire logic reqReady,
  output netport_pkg::netReq_type reqInfo,
  input wire logic rspValid,
  input wire netport_pkg::netRsp_type rspInfo,
  output logic keepData
);
  import netport_pkg::*;

  typedef struct packed {
    logic awHeld, wHeld, bValid, rValid, accepted, rejected, txValid, keep;
    logic [7:0] awAddr, idle, fault, noResp;
    logic [31:0] wData, rData, issue, presc;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;
    logic [4:0][15:0] ctrl;
    logic [15:0] rxLim, remote;
    logic [7:0][15:0] result, tmo, left, rxl;
    portst_type [7:0] pst;
    netReq_type [7:0] req;
    logic [7:0][3:0] retry;
    netReq_type txReq;
  } state_type;

  state_type q, n;
  logic tick, wrIssue, doIssue, wordsBad, selfDst, cfgOk;
  logic evTxLong, evRxLong, evRspOk, txPick;
  logic [7:0] evTmo, evRetry, busyMask, ofs, dNode, dUnit;
  logic [2:0] issPort, rspPort, txPort;
  logic [31:0] iw, mw;
  logic [6:0] dNet;
  unitcls_type dCls;
  kind_type kind;

  function automatic logic [31:0] mergeB(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      o[8*b +: 8] = s[b] ? v[8*b +: 8] : o[8*b +: 8];
    end
    return o;
  endfunction

  function automatic regk_type regKind(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == OFS_IDLE) return RK_IDLE;
    if (w == OFS_FAULT) return RK_FAULT;
    if (w >= OFS_RESULT && w < OFS_CTRL) return RK_RESULT;
    if (w >= OFS_CTRL && w < OFS_ISSUE) return RK_CTRL;
    if (w == OFS_ISSUE) return RK_ISSUE;
    if (w == OFS_RXLIM) return RK_RXLIM;
    if (w == OFS_STATUS) return RK_STATUS;
    return RK_NONE;
  endfunction

  function automatic unitcls_type unitClass(input logic [7:0] u);
    if (u == 8'h00) return UC_CPU;
    if (u == 8'h01) return UC_APP;
    if (u[7:4] == 4'h1) return UC_BUS;
    if (u == 8'hE1) return UC_INNER;
    if (u == 8'hFE) return UC_NET;
    return UC_BAD;
  endfunction

  assign awready = !q.awHeld && !q.bValid;
  assign wready = !q.wHeld && !q.bValid;
  assign bvalid = q.bValid;
  assign bresp = q.bResp;
  assign arready = !q.rValid;
  assign rvalid = q.rValid;
  assign rdata = q.rData;
  assign rresp = q.rResp;
  assign reqValid = q.txValid;
  assign reqInfo = q.txReq;
  assign keepData = q.keep;
  assign tick = (q.presc == 32'(TICK - 1));
  assign rspPort = rspInfo.port;
  assign txPort = q.txReq.port;
  assign issPort = q.ctrl[3][C3_PORT_LSB +: 3]; // RULE_14

  // Decode of the held control words for a new instruction
  always_comb begin
    dNet = q.ctrl[1][6:0];
    dNode = q.ctrl[2][15:8]; // RULE_12
    dUnit = q.ctrl[2][7:0];
    dCls = unitClass(dUnit); // RULE_13
    mw = mergeB(q.issue, q.wData, q.wStrb);
    kind = kind_type'(mw[1:0]);
    wordsBad = q.ctrl[0] < WORDS_MIN || q.ctrl[0] > WORDS_MAX; // RULE_10
    selfDst = kind == KIND_SEND && dUnit == 8'h00 && (dNode == NODE_LOCAL
              || (dNode == ownNode && (dNet == 7'h00 || dNet == lowestNet))); // RULE_17
    cfgOk = !wordsBad && q.ctrl[1][15:8] == 8'h00 && q.ctrl[1][7:0] <= NET_MAX // RULE_11
            && (q.ctrl[3] & C3_MBZ) == 16'h0000 && !q.ctrl[3][C3_PORT_HI] // RULE_14
            && kind != KIND_BAD && dCls != UC_BAD && !selfDst;
    for (int i = 0; i < NPORTS; i++) begin
      busyMask[i] = q.pst[i] != PS_IDLE;
    end
  end

  always_comb begin
    n = q;
    n.keep = 1'b0;
    wrIssue = 1'b0;
    doIssue = 1'b0;
    evTxLong = 1'b0;
    evRxLong = 1'b0;
    evRspOk = 1'b0;
    evTmo = 8'h00;
    evRetry = 8'h00;
    txPick = 1'b0;
    iw = 32'h0000_0000;
    ofs = 8'h00;
    n.presc = tick ? 32'h0000_0000 : q.presc + 32'h0000_0001;

    // Write channel: address and data may arrive in either order
    if (q.bValid && bready) n.bValid = 1'b0;
    if (awvalid && awready) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (q.awHeld && q.wHeld) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      ofs = q.awAddr - OFS_CTRL;
      unique case (regKind(q.awAddr))
        RK_CTRL: begin
          iw = mergeB({16'h0000, q.ctrl[ofs[4:2]]}, q.wData, q.wStrb);
          n.ctrl[ofs[4:2]] = iw[15:0];
        end
        RK_RXLIM: begin
          iw = mergeB({16'h0000, q.rxLim}, q.wData, q.wStrb);
          n.rxLim = iw[15:0];
        end
        RK_ISSUE: begin
          wrIssue = 1'b1;
          n.issue = mw;
          // Refuse busy ports and ports held by the protocol macro
          n.accepted = cfgOk && q.idle[issPort] && !protoBusy[issPort]; // RULE_01 RULE_05
          n.rejected = !n.accepted;
          if (n.accepted) begin
            if (kind == KIND_CMD && mw[31:16] > CMD_TX_MAX) begin
              evTxLong = 1'b1;
              n.fault[issPort] = 1'b1; // RULE_07
              n.result[issPort] = CODE_TXLONG;
            end else begin
              doIssue = 1'b1;
              n.idle[issPort] = 1'b0; // RULE_02
              n.result[issPort] = 16'h0000; // RULE_04
              n.pst[issPort] = PS_QUEUED;
              // Snapshot the destination; the data area itself is the caller's
              n.req[issPort] = '{port: issPort, kind: kind, // RULE_20
                net: (dNet == 7'h00) ? lowestNet : dNet, // RULE_18
                node: dNode, unit: dUnit, cls: dCls,
                words: q.ctrl[0][8:0], txBytes: mw[31:16]};
              n.retry[issPort] = q.ctrl[3][3:0];
              n.tmo[issPort] = (q.ctrl[4] == 16'h0000) ? TMO_DEFAULT : q.ctrl[4]; // RULE_15 RULE_16
              n.noResp[issPort] = q.ctrl[3][C3_NORSP] || dNode == NODE_BCAST; // RULE_21
              n.rxl[issPort] = (kind == KIND_CMD) ? q.rxLim : {6'h00, q.ctrl[0][8:0], 1'b0};
            end
          end
        end
        RK_NONE: n.bResp = RESP_SLVERR;
        default: ;
      endcase
    end

    // Read channel; read-only words show live port status
    if (q.rValid && rready) n.rValid = 1'b0;
    if (arvalid && !q.rValid) begin
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      n.rData = 32'h0000_0000;
      unique case (regKind(araddr))
        RK_IDLE: n.rData[7:0] = q.idle;
        RK_FAULT: n.rData[7:0] = q.fault; // RULE_03
        RK_RESULT: n.rData[15:0] = q.result[3'((araddr - OFS_RESULT) >> 2)];
        RK_CTRL: n.rData[15:0] = q.ctrl[3'((araddr - OFS_CTRL) >> 2)];
        RK_ISSUE: n.rData = q.issue;
        RK_RXLIM: n.rData[15:0] = q.rxLim;
        RK_STATUS: n.rData = {q.remote, 14'h0000, q.rejected, q.accepted};
        RK_NONE: n.rResp = RESP_SLVERR;
      endcase
    end

    // Hand a request to the network unit, lowest queued port first
    if (q.txValid && reqReady) begin
      n.txValid = 1'b0;
      if (q.noResp[txPort]) begin
        n.pst[txPort] = PS_IDLE; // RULE_21
        n.idle[txPort] = 1'b1; // RULE_23
        n.fault[txPort] = 1'b0;
        n.result[txPort] = 16'h0000;
      end else begin
        n.pst[txPort] = PS_WAIT;
        n.left[txPort] = q.tmo[txPort];
      end
    end
    if (!n.txValid) begin
      for (int i = 0; i < NPORTS; i++) begin
        if (q.pst[i] == PS_QUEUED && !txPick) begin
          txPick = 1'b1;
          n.txValid = 1'b1;
          n.txReq = q.req[i];
          n.pst[i] = PS_SEND;
        end
      end
    end

    // Response monitoring in tenths of a second
    for (int i = 0; i < NPORTS; i++) begin
      if (q.pst[i] == PS_WAIT && tick) begin
        if (q.left[i] > 16'h0001) begin
          n.left[i] = q.left[i] - 16'h0001;
        end else if (q.retry[i] != 4'h0) begin
          evRetry[i] = 1'b1;
          n.retry[i] = q.retry[i] - 4'h1; // RULE_22
          n.pst[i] = PS_QUEUED;
        end else begin
          evTmo[i] = 1'b1;
          n.pst[i] = PS_IDLE;
          n.idle[i] = 1'b1; // RULE_23
          n.fault[i] = 1'b1; // RULE_06
          n.result[i] = CODE_TMO;
        end
      end
    end

    // A response beats a time-out in the same cycle
    if (rspValid && q.pst[rspPort] == PS_WAIT) begin
      evTmo[rspPort] = 1'b0;
      evRetry[rspPort] = 1'b0;
      n.retry[rspPort] = q.retry[rspPort];
      n.pst[rspPort] = PS_IDLE;
      n.idle[rspPort] = 1'b1; // RULE_23
      if (rspInfo.bytes > q.rxl[rspPort]) begin
        evRxLong = 1'b1;
        n.fault[rspPort] = 1'b1; // RULE_08
        n.result[rspPort] = CODE_RXLONG;
      end else begin
        evRspOk = 1'b1;
        n.keep = 1'b1;
        n.fault[rspPort] = 1'b0; // RULE_09
        n.result[rspPort] = 16'h0000;
        n.remote = rspInfo.code;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
      q.idle <= IDLE_RST;
    end else begin
      q <= n;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_onePerPort;
    wrIssue && !q.idle[issPort] |-> !doIssue;
  endproperty
  a_onePerPort: assert property (p_onePerPort) else $error("Busy port took a new one"); // RULE_01
  property p_idleFlag;
    (q.idle & busyMask) == 8'h00 && (q.idle | busyMask) == 8'hFF;
  endproperty
  a_idleFlag: assert property (p_idleFlag) else $error("Idle flag disagrees"); // RULE_02
  property p_resultClr;
    doIssue |=> q.result[$past(issPort)] == 16'h0000 && !q.idle[$past(issPort)];
  endproperty
  a_resultClr: assert property (p_resultClr) else $error("Start did not clear"); // RULE_04
  property p_macro;
    wrIssue && protoBusy[issPort] |-> !doIssue && !evTxLong;
  endproperty
  a_macro: assert property (p_macro) else $error("Macro-held port used"); // RULE_05
  property p_tmo;
    |evTmo |=> (q.fault & $past(evTmo)) == $past(evTmo) && (q.idle & $past(evTmo)) != 8'h00;
  endproperty
  a_tmo: assert property (p_tmo) else $error("Time-out not flagged"); // RULE_06
  property p_txLong;
    evTxLong |=> q.fault[$past(issPort)] && q.result[$past(issPort)] == CODE_TXLONG;
  endproperty
  a_txLong: assert property (p_txLong) else $error("Long command not flagged"); // RULE_07
  property p_rxLong;
    evRxLong |=> q.fault[$past(rspPort)] && !keepData;
  endproperty
  a_rxLong: assert property (p_rxLong) else $error("Long response kept"); // RULE_08
  property p_remote;
    evRspOk |=> !q.fault[$past(rspPort)] && q.result[$past(rspPort)] == 16'h0000 && keepData;
  endproperty
  a_remote: assert property (p_remote) else $error("Remote code leaked"); // RULE_09 RULE_23
  property p_words;
    wrIssue && wordsBad |-> !doIssue;
  endproperty
  a_words: assert property (p_words) else $error("Bad word count taken"); // RULE_10
  property p_bcast;
    reqValid && reqReady && reqInfo.node == NODE_BCAST |=> q.idle[$past(txPort)];
  endproperty
  a_bcast: assert property (p_bcast) else $error("Broadcast waited"); // RULE_21

  c_issue: cover property (doIssue);
  c_retry: cover property (|evRetry);
  c_tmo: cover property (|evTmo);
  c_rxLong: cover property (evRxLong);
endmodule

// file: net_unit_model.sv
// Behavioural network unit facing the port manager's request side.
// Assumes sys_clk and srst shared with the manager; the bench steers it.
`timescale 1ns/10ps
module net_unit_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reqValid,
  output logic reqReady,
  input wire netport_pkg::netReq_type reqInfo,
  output logic rspValid,
  output netport_pkg::netRsp_type rspInfo,
  input wire logic silent,
  input wire logic [15:0] rspBytes,
  input wire logic [15:0] rspCode,
  input wire logic [7:0] delay,
  output int taken,
  output netport_pkg::netReq_type lastReq
);
  import netport_pkg::*;
  logic pending;
  logic [7:0] waitCnt;
  logic [2:0] port;
  // One answer in flight: a slow answer stalls further requests
  assign reqReady = !pending;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pending <= 1'h0;
      rspValid <= 1'h0;
      rspInfo <= '0;
      taken <= 0;
    end else begin
      rspValid <= 1'h0;
      // Idle lines toggle so a stale value never passes for an answer
      rspInfo <= ~rspInfo;
      if (reqValid && reqReady) begin
        taken <= taken + 1;
        lastReq <= reqInfo;
        pending <= !silent && reqInfo.node != NODE_BCAST;
        waitCnt <= delay;
        port <= reqInfo.port;
      end else if (pending) begin
        if (waitCnt == 8'h00) begin
          pending <= 1'h0;
          rspValid <= 1'h1;
          rspInfo <= netRsp_type'{port, rspBytes, rspCode};
        end else begin
          waitCnt <= waitCnt - 8'h01;
        end
      end
    end
  end
endmodule

// file: network_instruction_ports_tb.sv
// Self-checking bench for the network instruction port manager.
// Acts as AXI4-Lite master; the network unit model answers requests.
`timescale 1ns/10ps
module network_instruction_ports_tb;
  import netport_pkg::*;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, protoBusy = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, reqValid, reqReady, rspValid, keepData;
  logic [1:0] bresp, rresp, lastResp;
  netReq_type reqInfo, lastReq;
  netRsp_type rspInfo;
  logic silent = 1'h0;
  logic [15:0] rspBytes = 16'h0002, rspCode = 16'h0000;
  logic [7:0] delay = 8'h05;
  int taken, errors = 0, checks_done = 0, kd = 0, cyc = 0, t0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (keepData === 1'h1) kd++;
  end
  netport_mgr #(.TICK(10)) dut (.sys_clk(sys_clk), .srst(srst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .protoBusy(protoBusy), .lowestNet(7'h15), .ownNode(8'h09),
    .reqValid(reqValid), .reqReady(reqReady), .reqInfo(reqInfo), .rspValid(rspValid),
    .rspInfo(rspInfo), .keepData(keepData));
  net_unit_model partner (.sys_clk(sys_clk), .srst(srst), .reqValid(reqValid),
    .reqReady(reqReady), .reqInfo(reqInfo), .rspValid(rspValid), .rspInfo(rspInfo),
    .silent(silent), .rspBytes(rspBytes), .rspCode(rspCode), .delay(delay),
    .taken(taken), .lastReq(lastReq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("ERROR at %0t: wait ran out", $time);
    results();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge sys_clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      lastResp = bresp;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) bready <= 1'h0;
    end
    if (!b) hang();
  endtask
  task automatic axr(input logic [7:0] a);
    logic ar, r;
    r = 1'h0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge sys_clk);
      ar = arvalid && arready;
      r = rvalid;
      v = rdata;
      lastResp = rresp;
      @(posedge sys_clk);
      if (ar) arvalid <= 1'h0;
      if (r) rready <= 1'h0;
    end
    if (!r) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    check(v, e);
  endtask
  task automatic go(input logic [15:0] c0, c1, c2, c3, c4, input logic [31:0] iss);
    axw(OFS_CTRL, {16'h0000, c0});
    axw(OFS_CTRL + 8'h04, {16'h0000, c1});
    axw(OFS_CTRL + 8'h08, {16'h0000, c2});
    axw(OFS_CTRL + 8'h0C, {16'h0000, c3});
    axw(OFS_CTRL + 8'h10, {16'h0000, c4});
    axw(OFS_ISSUE, iss);
  endtask
  task automatic waitIdle(input logic [7:0] m);
    for (int n = 0; n < 120; n++) begin
      axr(OFS_IDLE);
      if ((v[7:0] & m) === m) return;
    end
    hang();
  endtask
  task automatic t_reset;
    rd(OFS_IDLE, 32'hFF);
    rd(OFS_FAULT, 32'h0);
    for (int p = 0; p < NPORTS; p++) rd(OFS_RESULT + 8'(4 * p), 32'h0);
    axw(OFS_IDLE, 32'h0);
    check(32'(lastResp), 32'(RESP_OKAY));
    rd(OFS_IDLE, 32'hFF);
    axr(8'h80);
    check(32'(lastResp), 32'(RESP_SLVERR));
    $display("reset and map test done");
  endtask
  task automatic t_send;
    int k0;
    k0 = kd;
    rspCode <= 16'h0040;
    delay <= 8'h08;
    go(16'h0002, 16'h0000, 16'h0510, 16'h0300, 16'h0005, 32'h0);
    rd(OFS_IDLE, 32'hF7);
    waitIdle(8'h08);
    check(32'(lastReq.net), 32'h15);
    check({16'h0, lastReq.node, lastReq.unit}, 32'h0510);
    check(32'(lastReq.words), 32'h2);
    check(32'(lastReq.port), 32'h3);
    rd(OFS_FAULT, 32'h0);
    rd(OFS_RESULT + 8'h0C, 32'h0);
    rd(OFS_STATUS, 32'h00400001);
    check(32'(kd - k0), 32'h1);
    $display("send test done");
  endtask
  task automatic t_timeout;
    silent <= 1'h1;
    t0 = taken;
    go(16'h0001, 16'h0003, 16'h0710, 16'h0102, 16'h0001, 32'h0);
    axw(OFS_ISSUE, 32'h0);
    axr(OFS_STATUS);
    check(32'(v[1:0]), 32'h2);
    go(16'h0001, 16'h0003, 16'h0710, 16'h0200, 16'h0001, 32'h0);
    axr(OFS_STATUS);
    check(32'(v[1:0]), 32'h1);
    waitIdle(8'h06);
    check(32'(taken - t0), 32'h4);
    rd(OFS_FAULT, 32'h06);
    rd(OFS_RESULT + 8'h04, 32'h0205);
    silent <= 1'h0;
    delay <= 8'h20;
    go(16'h0001, 16'h0003, 16'h0710, 16'h0100, 16'h0010, 32'h0);
    rd(OFS_RESULT + 8'h04, 32'h0);
    waitIdle(8'h02);
    rd(OFS_FAULT, 32'h04);
    $display("time-out test done");
  endtask
  task automatic t_default;
    silent <= 1'h1;
    go(16'h0001, 16'h0000, 16'h0510, 16'h0000, 16'h0000, 32'h0);
    t0 = cyc;
    waitIdle(8'h01);
    check(32'(cyc - t0 >= 188 && cyc - t0 <= 215), 32'h1);
    rd(OFS_RESULT, 32'h0205);
    $display("default time-out test done");
  endtask
  task automatic t_bcast;
    for (int i = 0; i < 2; i++) begin
      silent <= 1'(i);
      t0 = taken;
      go(16'h0001, 16'h0000, i ? 16'h0510 : 16'hFF10, i ? 16'h8303 : 16'h0303, 16'h0001, 32'h0);
      waitIdle(8'h08);
      check(32'(taken - t0), 32'h1);
      axr(OFS_FAULT);
      check(32'(v[3]), 32'h0);
    end
    $display("broadcast test done");
  endtask
  task automatic t_decode;
    logic [7:0] u [6] = '{8'h00, 8'h01, 8'h10, 8'h1F, 8'hE1, 8'hFE};
    unitcls_type c [6] = '{UC_CPU, UC_APP, UC_BUS, UC_BUS, UC_INNER, UC_NET};
    silent <= 1'h0;
    delay <= 8'h00;
    for (int i = 0; i < 6; i++) begin
      go(16'h0001, 16'h0000, {8'h05, u[i]}, 16'h0600, 16'h0005, 32'h0);
      waitIdle(8'h40);
      check(32'(lastReq.cls), 32'(c[i]));
      check(32'(lastReq.unit), 32'(u[i]));
    end
    $display("unit decode test done");
  endtask
  task automatic t_reject;
    logic [63:0] tb [11] = '{64'h0000_0000_0510_0200, 64'h0101_0000_0510_0200,
      64'h0001_0080_0510_0200, 64'h0001_0100_0510_0200, 64'h0001_0000_0510_0210,
      64'h0001_0000_0510_1200, 64'h0001_0000_0502_0200, 64'h0001_0000_0000_0200,
      64'h0001_0000_0510_0500, 64'h0001_0000_0510_0200, 64'h0001_0015_0900_0200};
    protoBusy <= 8'h20;
    for (int i = 0; i < 11; i++) begin
      go(tb[i][63:48], tb[i][47:32], tb[i][31:16], tb[i][15:0], 16'h0001, 32'(i == 9 ? 3 : 0));
      axr(OFS_STATUS);
      check(32'(v[1:0]), 32'h2);
    end
    protoBusy <= 8'h00;
    rd(OFS_IDLE, 32'hFF);
    $display("refusal test done");
  endtask
  task automatic t_cmd;
    int k0;
    rspBytes <= 16'h0006;
    delay <= 8'h02;
    axw(OFS_RXLIM, 32'h4);
    go(16'h0001, 16'h0000, 16'h0510, 16'h0400, 16'h0005, 32'h021F0002);
    rd(OFS_IDLE, 32'hFF);
    rd(OFS_RESULT + 8'h10, 32'h1103);
    k0 = kd;
    axw(OFS_ISSUE, 32'h021E0002);
    waitIdle(8'h10);
    rd(OFS_RESULT + 8'h10, 32'h1104);
    check(32'(kd - k0), 32'h0);
    check({lastReq.txBytes, 14'h0000, lastReq.kind}, 32'h021E0002);
    axr(OFS_FAULT);
    check(32'(v[4]), 32'h1);
    $display("command length test done");
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'h0;
    t_reset();
    t_send();
    t_timeout();
    t_default();
    t_bcast();
    t_decode();
    t_reject();
    t_cmd();
    results();
  end
endmodule
